//--- logic/pcm_clock_power.sv
// Clock and power management: strap mode, fundamental clock, power-save divider, clock outputs
module pcm_clock_power
(
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst_b,
	input  wire logic                  i_oscillator_input,
	output logic                       o_oscillator_output,
	input  wire logic                  i_clock_strap_one,
	input  wire logic                  i_clock_strap_two,
	input  wire logic                  i_hw_irq,
	input  wire logic                  i_bus_t3,
	input  wire pcm_pkg::pcm_reg_req_t i_reg_req,
	output logic [15:0]                o_reg_rdata,
	output logic                       o_pll_enable,
	output logic [1:0]                 o_clock_mode,
	output logic                       o_cpu_clock,
	output logic                       o_primary_clock_out,
	output logic                       o_primary_clock_oe,
	output logic                       o_secondary_clock_out,
	output logic                       o_secondary_clock_oe
);
	import pcm_pkg::*;

	typedef struct packed {
		logic        osc_s1;
		logic        osc_s2;
		logic        osc_d;
		logic [1:0]  strap_s1;
		logic [1:0]  strap_s2;
		pcm_mode_t   mode;
		pcm_ctrl_t   ctrl;
		logic [15:0] pcnt;
		logic [15:0] period;
		logic [15:0] hcnt;
		logic        x4_clk;
		logic        div2_clk;
		logic        fund_d;
		logic [7:0]  dcnt;
		logic        ps_active;
		logic        irq_pend;
		logic        a_src_fund;
		logic        b_src_fund;
		logic        cpu_clk;
		logic        a_out;
		logic        b_out;
		logic [15:0] rdata;
		logic        osc_out;
	} pcm_state_t;

	pcm_state_t st;
	pcm_state_t next_st;
	logic       fund;
	logic       dclk;
	logic       osc_rise;
	logic       both_low;
	logic [15:0] half_step;

	// Decode strap pair into a mode; any pattern other than x4 or x1 is divide by two
	function automatic pcm_mode_t strap_mode(input logic [1:0] s);
		case (s)
			PCM_STRAP_X4: strap_mode = PCM_MODE_X4;
			PCM_STRAP_X1: strap_mode = PCM_MODE_X1;
			default:      strap_mode = PCM_MODE_DIV2;
		endcase
	endfunction

	// Fundamental clock picked by the latched mode
	always_comb
	begin
		case (st.mode)
			PCM_MODE_DIV2: fund = st.div2_clk;
			PCM_MODE_X1:   fund = st.osc_s2;
			PCM_MODE_X4:   fund = st.x4_clk;
			default:       fund = st.div2_clk;
		endcase
	end

	// Power-save clock is a power-of-two division of the fundamental clock
	assign dclk      = st.dcnt[st.ctrl.div];
	assign osc_rise  = st.osc_s2 & ~st.osc_d;
	// Sources may only be swapped while both are low, so no short pulse escapes
	assign both_low  = ~fund & ~dclk;
	assign half_step = ((st.period >> PCM_X4_SHIFT) == 16'h0000) ? 16'h0001 : (st.period >> PCM_X4_SHIFT);

	// Next-state logic for the whole block
	always_comb
	begin
		next_st          = st;
		// Oscillator and strap pins pass two flip-flops before use
		next_st.osc_s1   = i_oscillator_input;
		next_st.osc_s2   = st.osc_s1;
		next_st.osc_d    = st.osc_s2;
		next_st.strap_s1 = {i_clock_strap_two, i_clock_strap_one};
		next_st.strap_s2 = st.strap_s1;
		next_st.osc_out  = ~st.osc_s2;
		// Divide by two toggles on every crystal rising edge
		if (osc_rise)
			next_st.div2_clk = ~st.div2_clk;
		// Times four: measure the crystal period, toggle every eighth of it
		if (osc_rise)
		begin
			next_st.period = st.pcnt + 16'h0001;
			next_st.pcnt   = 16'h0000;
			next_st.hcnt   = 16'h0000;
			next_st.x4_clk = 1'b1;
		end
		else
		begin
			if (st.pcnt != 16'hffff)
				next_st.pcnt = st.pcnt + 16'h0001;
			if (st.hcnt + 16'h0001 >= half_step)
			begin
				next_st.hcnt   = 16'h0000;
				next_st.x4_clk = ~st.x4_clk;
			end
			else
				next_st.hcnt = st.hcnt + 16'h0001;
		end
		// Divider counts fundamental rising edges
		next_st.fund_d = fund;
		if (fund & ~st.fund_d)
			next_st.dcnt = st.dcnt + 8'h01;
		// Register write; the mode field is read-only
		if (i_reg_req.wr && i_reg_req.addr == PCM_CTRL_OFFSET)
		begin
			next_st.ctrl         = pcm_ctrl_t'(i_reg_req.wdata);
			next_st.ctrl.mode_ro = 2'h0;
		end
		// Interrupt while in power-save is held until the next phase-three edge
		if (st.ctrl.psen && i_hw_irq)
			next_st.irq_pend = 1'b1;
		else if (!st.ctrl.psen)
			next_st.irq_pend = 1'b0; // A stale request must not end a later power-save
		if ((st.irq_pend || (st.ctrl.psen && i_hw_irq)) && i_bus_t3)
		begin
			next_st.ctrl.psen = 1'b0;
			next_st.irq_pend  = 1'b0;
		end
		// CPU clock source change waits for both sources low
		if (both_low)
			next_st.ps_active = st.ctrl.psen;
		next_st.cpu_clk = next_st.ps_active ? dclk : fund;
		// Output source selection, also glitch-free
		if (~fund & ~next_st.cpu_clk)
		begin
			next_st.a_src_fund = st.ctrl.a_fund;
			next_st.b_src_fund = st.ctrl.b_fund;
		end
		next_st.a_out = next_st.a_src_fund ? fund : next_st.cpu_clk;
		next_st.b_out = next_st.b_src_fund ? fund : next_st.cpu_clk;
		// Read data with the mode shown in its field
		next_st.rdata = 16'h0000;
		if (i_reg_req.rd && i_reg_req.addr == PCM_CTRL_OFFSET)
		begin
			next_st.rdata = st.ctrl;
			next_st.rdata[PCM_MODE_LSB +: 2] = (st.mode == PCM_MODE_X4) ? PCM_CODE_X4 :
				(st.mode == PCM_MODE_X1) ? PCM_CODE_X1 : PCM_CODE_DIV2;
		end
		// Synchronous reset: control state to defaults, mode caught from the straps
		if (!i_rst_b)
		begin
			next_st.mode       = strap_mode(st.strap_s2);
			next_st.ctrl       = pcm_ctrl_t'(PCM_CTRL_RESET);
			next_st.pcnt       = 16'h0000;
			next_st.period     = 16'h0008;
			next_st.hcnt       = 16'h0000;
			next_st.x4_clk     = 1'b0;
			next_st.div2_clk   = 1'b0;
			next_st.fund_d     = 1'b0;
			next_st.dcnt       = 8'h00;
			next_st.ps_active  = 1'b0;
			next_st.irq_pend   = 1'b0;
			next_st.a_src_fund = 1'b1;
			next_st.b_src_fund = 1'b1;
			next_st.cpu_clk    = 1'b0;
			next_st.a_out      = 1'b0;
			next_st.b_out      = 1'b0;
			next_st.rdata      = 16'h0000;
			next_st.osc_out    = 1'b0;
		end
	end

	// Single state register
	always_ff @(posedge i_clk_sys)
		st <= next_st;

	// Outputs straight from flip-flops, except o_pll_enable, which is decoded from the mode
	assign o_oscillator_output   = st.osc_out;
	assign o_reg_rdata           = st.rdata;
	assign o_pll_enable          = (st.mode != PCM_MODE_DIV2);
	assign o_clock_mode          = st.mode;
	assign o_cpu_clock           = st.cpu_clk;
	assign o_primary_clock_out   = st.a_out;
	assign o_primary_clock_oe    = st.ctrl.a_en;
	assign o_secondary_clock_out = st.b_out;
	assign o_secondary_clock_oe  = st.ctrl.b_en;

	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	a_div2_rate: assert property (st.mode == PCM_MODE_DIV2 && osc_rise |=> st.div2_clk != $past(st.div2_clk))
		else $error("divide by two clock missed a toggle");
	a_div2_pll_off: assert property (st.mode == PCM_MODE_DIV2 |-> !o_pll_enable && fund == st.div2_clk)
		else $error("pll on or wrong source in divide by two");
	a_x1_follow: assert property (st.mode == PCM_MODE_X1 |-> o_pll_enable && fund == st.osc_s2)
		else $error("times one clock does not follow crystal");
	a_x4_restart: assert property (st.mode == PCM_MODE_X4 && osc_rise |=> st.x4_clk && st.hcnt == 16'h0000)
		else $error("times four clock not aligned to crystal edge");
	a_mode_hold: assert property ($past(i_rst_b) |-> $stable(st.mode))
		else $error("clock mode changed outside reset");
	a_default_x4: assert property (disable iff (1'b0) !i_rst_b && st.strap_s2 == PCM_STRAP_X4 |=> st.mode == PCM_MODE_X4)
		else $error("high straps did not give times four");
	a_out_oe: assert property (i_reg_req.wr && i_reg_req.addr == PCM_CTRL_OFFSET
		|=> o_primary_clock_oe == $past(i_reg_req.wdata[PCM_A_EN_BIT])
		&& o_secondary_clock_oe == $past(i_reg_req.wdata[PCM_B_EN_BIT]))
		else $error("clock driver enable not from register");
	a_out_select: assert property ($past(i_rst_b) && st.a_src_fund && $past(st.a_src_fund)
		|-> o_primary_clock_out == $past(fund))
		else $error("primary output not on fundamental clock");
	a_ps_divided: assert property (st.ps_active && $past(st.ps_active) |-> o_cpu_clock == $past(dclk))
		else $error("power-save cpu clock not divided");
	a_irq_return: assert property (st.irq_pend && i_bus_t3 && !(i_reg_req.wr && i_reg_req.addr == PCM_CTRL_OFFSET)
		|=> !st.ctrl.psen ##[1:1000] !st.ps_active)
		else $error("interrupt did not end power-save");
	a_switch_low: assert property (st.ps_active != $past(st.ps_active) |-> !$past(fund) && !$past(dclk))
		else $error("clock switch while a source was high");

	c_x4_mode: cover property (st.mode == PCM_MODE_X4 && osc_rise);
	c_ps_enter: cover property (!st.ps_active ##1 st.ps_active);
	c_irq_exit: cover property (st.irq_pend && i_bus_t3);
	c_b_off: cover property (!o_secondary_clock_oe && o_primary_clock_oe);

endmodule // pcm_clock_power

//--- logic/pcm_pkg.sv
// Package for the clock and power management block: offsets, field layout, encodings
package pcm_pkg;

	// Register offset inside the peripheral control block
	localparam logic [7:0]  PCM_CTRL_OFFSET = 8'hf0;
	// Control register value after reset: both drivers on, both outputs on the fundamental clock
	localparam logic [15:0] PCM_CTRL_RESET  = 16'h3300;
	// Field positions of the control register
	localparam int          PCM_DIV_LSB     = 0;
	localparam int          PCM_MODE_LSB    = 4;
	localparam int          PCM_A_FUND_BIT  = 8;
	localparam int          PCM_B_FUND_BIT  = 9;
	localparam int          PCM_A_EN_BIT    = 12;
	localparam int          PCM_B_EN_BIT    = 13;
	localparam int          PCM_PSEN_BIT    = 15;
	// Strap encoding {clock_strap_two, clock_strap_one}; pulled-high straps give times four
	localparam logic [1:0]  PCM_STRAP_X4    = 2'h3;
	localparam logic [1:0]  PCM_STRAP_X1    = 2'h1;
	// Mode code shown in the read-back field
	localparam logic [1:0]  PCM_CODE_DIV2   = 2'h0;
	localparam logic [1:0]  PCM_CODE_X1     = 2'h1;
	localparam logic [1:0]  PCM_CODE_X4     = 2'h2;
	// Step of the times-four generator: eight half periods per input period
	localparam int          PCM_X4_SHIFT    = 3;

	typedef enum logic [1:0] {PCM_MODE_DIV2, PCM_MODE_X1, PCM_MODE_X4} pcm_mode_t;

	// Control register layout
	typedef struct packed {
		logic       psen;
		logic       rsv14;
		logic       b_en;
		logic       a_en;
		logic [1:0] rsv11;
		logic       b_fund;
		logic       a_fund;
		logic [1:0] rsv7;
		logic [1:0] mode_ro;
		logic       rsv3;
		logic [2:0] div;
	} pcm_ctrl_t;

	// Register access from the peripheral control block decoder
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} pcm_reg_req_t;

endpackage : pcm_pkg

//--- testbench/pcm_osc_model.sv
// Free-running crystal stand-in that drives the oscillator input pin
module pcm_osc_model
#(
	parameter int HALF_NS = 320
)
(
	output logic o_osc
);
	timeunit 1ns;
	timeprecision 1ns;

	// A crystal never stops; the 7 ns offset keeps its edges away from the system clock edges
	initial
	begin
		o_osc = 1'b0;
		#7;
		forever #(HALF_NS) o_osc = ~o_osc;
	end
endmodule // pcm_osc_model

//--- testbench/tb_pll_clock_power_manager.sv
// Self-checking bench for the clock and power management block
module tb_pll_clock_power_manager;
	timeunit 1ns;
	timeprecision 1ns;
	import pcm_pkg::*;

	typedef struct packed {logic [1:0] strap; logic [1:0] code; logic pll; int per;} pcm_row_t;
	// Crystal period is 16 system cycles, so times four gives 4, times one 16, divide by two 32
	pcm_row_t     rows [4] = '{'{2'h0, PCM_CODE_DIV2, 1'b0, 32}, '{2'h2, PCM_CODE_DIV2, 1'b0, 32},
	                           '{2'h1, PCM_CODE_X1, 1'b1, 16}, '{2'h3, PCM_CODE_X4, 1'b1, 4}};
	logic         clk_sys = 1'b0;
	logic         rst_b = 1'b0;
	logic         strap_one = 1'b1;
	logic         strap_two = 1'b1;
	logic         hw_irq = 1'b0;
	logic         bus_t3 = 1'b0;
	pcm_reg_req_t req = '0;
	logic         osc;
	logic         osc_out;
	logic [2:0]   osc_hist = 3'h0;
	logic [15:0]  rdata;
	logic [1:0]   mode;
	logic         pll_en, cpu_clk, pri_clk, pri_oe, sec_clk, sec_oe;
	int           err_total = 0;
	int           n_checks = 0;
	int           edges;

	always #20 clk_sys = ~clk_sys;

	// Pin history: the amplifier output shows the inverse of the pin three edges later
	always @(posedge clk_sys)
		osc_hist <= {osc_hist[1:0], osc};

	pcm_osc_model i_pcm_osc_model (.o_osc(osc));

	pcm_clock_power i_pcm_clock_power (
		.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_oscillator_input(osc), .o_oscillator_output(osc_out),
		.i_clock_strap_one(strap_one), .i_clock_strap_two(strap_two), .i_hw_irq(hw_irq),
		.i_bus_t3(bus_t3), .i_reg_req(req), .o_reg_rdata(rdata), .o_pll_enable(pll_en),
		.o_clock_mode(mode), .o_cpu_clock(cpu_clk), .o_primary_clock_out(pri_clk),
		.o_primary_clock_oe(pri_oe), .o_secondary_clock_out(sec_clk), .o_secondary_clock_oe(sec_oe));

	// Verdict and end of run, shared by the main sequence and the watchdog
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Inputs other than the crystal pin change 1 ns after the rising edge, from the first edge on
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// One register access; read data is registered at the taking edge
	task automatic reg_acc(input logic wr, input logic [7:0] addr, input logic [15:0] wdata);
		req = '{wr, ~wr, addr, wdata};
		cyc(1);
		req = '0;
		cyc(1);
	endtask

	task automatic reg_rd(input logic [7:0] addr, input logic [15:0] exp, input string what);
		logic [15:0] got;
		req = '{1'b0, 1'b1, addr, 16'h0000};
		cyc(1);
		got = rdata;
		req = '0;
		cyc(1);
		check(got, exp, what);
	endtask

	// Rising edges are counted on sampled waveforms, so one edge of slack covers the phase
	task automatic check_rate(input int sel, input int n, input int per, input string what);
		logic prev, cur;
		edges = 0;
		prev = 1'b1;
		repeat (n)
		begin
			cyc(1);
			cur = (sel == 0) ? pri_clk : (sel == 1) ? sec_clk : cpu_clk;
			if (cur === 1'b1 && prev === 1'b0)
				edges++;
			prev = cur;
		end
		check(16'(edges >= n / per - 1 && edges <= n / per + 1), 16'h1, what);
	endtask

	// Straps are held for the whole reset and long enough after it for the clocks to settle
	task automatic do_reset(input logic [1:0] strap);
		{strap_two, strap_one} = strap;
		rst_b = 1'b0;
		cyc(6);
		rst_b = 1'b1;
		cyc(64);
	endtask

	// Watchdog: all tests take about 3500 cycles
	initial
	begin
		#(40 * 20000);
		err_total++;
		complete_run();
	end

	// Strap rows first, ending in the default mode; then the register and power-save cases
	initial
	begin
		foreach (rows[k])
		begin
			do_reset(rows[k].strap);
			check(16'(mode), 16'(rows[k].code), "mode");
			check(16'(pll_en), 16'(rows[k].pll), "pll enable");
			reg_rd(PCM_CTRL_OFFSET, PCM_CTRL_RESET | (16'(rows[k].code) << PCM_MODE_LSB), "reset");
			check_rate(0, 512, rows[k].per, "primary rate");
		end
		check(16'(mode), 16'(PCM_CODE_X4), "default mode");
		{strap_two, strap_one} = 2'h0;
		cyc(8);
		check(16'(mode), 16'(PCM_CODE_X4), "straps after reset");
		check(16'({pri_oe, sec_oe}), 16'h3, "reset enables");
		reg_acc(1'b1, PCM_CTRL_OFFSET, 16'h1010);
		check(16'({pri_oe, sec_oe}), 16'h2, "single enable");
		reg_acc(1'b1, 8'hf2, 16'hffff);
		reg_rd(8'hf2, 16'h0000, "unmapped read");
		reg_rd(PCM_CTRL_OFFSET, 16'h1020, "mode read-only");
		// Power-save at quarter rate on the secondary output, fundamental on the primary
		reg_acc(1'b1, PCM_CTRL_OFFSET, 16'hb101);
		cyc(16);
		check_rate(1, 256, 16, "secondary power-save");
		check_rate(0, 256, 4, "primary fundamental");
		check_rate(2, 256, 16, "cpu power-save");
		// Phase three alone must not end power-save; interrupt then phase three does
		bus_t3 = 1'b1;
		cyc(1);
		bus_t3 = 1'b0;
		cyc(2);
		reg_rd(PCM_CTRL_OFFSET, 16'hb121, "no interrupt");
		hw_irq = 1'b1;
		cyc(1);
		hw_irq = 1'b0;
		cyc(3);
		reg_rd(PCM_CTRL_OFFSET, 16'hb121, "before phase three");
		bus_t3 = 1'b1;
		cyc(1);
		bus_t3 = 1'b0;
		cyc(2);
		reg_rd(PCM_CTRL_OFFSET, 16'h3121, "after phase three");
		cyc(16);
		check_rate(2, 256, 4, "cpu fundamental");
		// Interrupt and phase three in one cycle end power-save at once
		reg_acc(1'b1, PCM_CTRL_OFFSET, 16'hb101);
		hw_irq = 1'b1;
		bus_t3 = 1'b1;
		cyc(1);
		hw_irq = 1'b0;
		bus_t3 = 1'b0;
		cyc(2);
		reg_rd(PCM_CTRL_OFFSET, 16'h3121, "irq with phase three");
		// Interrupt outside power-save is ignored
		hw_irq = 1'b1;
		cyc(1);
		hw_irq = 1'b0;
		reg_acc(1'b1, PCM_CTRL_OFFSET, 16'hb101);
		bus_t3 = 1'b1;
		cyc(1);
		bus_t3 = 1'b0;
		cyc(2);
		reg_rd(PCM_CTRL_OFFSET, 16'hb121, "irq outside power-save");
		// A request left from an earlier power-save must not end the next one
		hw_irq = 1'b1;
		cyc(1);
		hw_irq = 1'b0;
		reg_acc(1'b1, PCM_CTRL_OFFSET, 16'h3101);
		reg_acc(1'b1, PCM_CTRL_OFFSET, 16'hb101);
		bus_t3 = 1'b1;
		cyc(1);
		bus_t3 = 1'b0;
		cyc(2);
		reg_rd(PCM_CTRL_OFFSET, 16'hb121, "stale interrupt");
		// Amplifier output is the inverted pin, two sync stages and one output stage late
		repeat (32)
		begin
			cyc(1);
			check(16'(osc_out ^ osc_hist[2]), 16'h1, "oscillator output");
		end
		complete_run();
	end
endmodule // tb_pll_clock_power_manager
